//--- logic/tpwm_pkg.sv
// Summary of operation
// - A channel's cycle starts when its high-side gate is switched off.
// - Channel two ends its pulse exactly half a cycle after channel one.
// - Low-side gate stays on at least one third cycle after high-side off.
// - High-side turn-on is armed only after that one-third interval.
// - Armed high-side turns on when ramp reaches adjusted error value.
// - Low-side gate drops just before high-side rises; never both on.
// - High-side stays on until the next cycle boundary ends the pulse.
// - Larger error word gives larger duty on both channels.
// - Comparator result drives the high-side output without inversion.
// - Each channel's current is sampled once per cycle during low-side conduction.
// - Both channel samples share one multiplexed sense path.
// - Correction equals channel current minus the average of both currents.
// - Above-average channel has its pulse width reduced by its correction.
// - Each sensed current goes to balance logic and to overcurrent output.
// - Duty per channel never exceeds 66 percent of the cycle.
// - Current sample is taken in the middle of the forced one-third low-side interval.
// - Enable low disables operation; enable high allows it.
package tpwm_pkg;
   localparam int          CNT_W     = 8;
   localparam int          CUR_W     = 8;
   localparam int          NCH       = 2;
   localparam logic [7:0]  PERIOD    = 8'd150;
   localparam logic [7:0]  HALF      = 8'd75;
   localparam logic [7:0]  THIRD     = 8'd50;
   localparam logic [7:0]  MID_LOW   = 8'd25;
   localparam logic [7:0]  DEAD      = 8'd1;
   localparam logic [7:0]  CNT_RST   = 8'h00;
   localparam logic [7:0]  CUR_RST   = 8'h00;
   typedef enum logic [1:0] {TPWM_FORCED, TPWM_ARMED, TPWM_DEAD, TPWM_HIGH} tpwm_ph_t;
endpackage

//--- logic/tpwm_chan.sv
`timescale 1ns/10ps
// One channel: ramp, arming, dead time, pulse and sample strobe.
module tpwm_chan
   import tpwm_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             en,
   input  wire logic             boundary,
   input  wire logic [CNT_W-1:0] thresh,
   output logic                  hs,
   output logic                  ls,
   output logic                  sample
);
   typedef struct packed {
      tpwm_ph_t         ph;
      logic [CNT_W-1:0] ramp;
      logic             hs;
      logic             ls;
      logic             sample;
   } tpwm_ch_st_t;

   tpwm_ch_st_t st_ff;
   tpwm_ch_st_t nxt_st;

   // Phase sequencer; the boundary wins over every phase (only enable low outranks it) so the pulse cannot outlive its cycle.
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.sample = 1'b0;
      nxt_st.ramp   = st_ff.ramp + 8'd1;
      if (!en) begin
         nxt_st.ph   = TPWM_FORCED;
         nxt_st.ramp = CNT_RST;
         nxt_st.hs   = 1'b0;
         nxt_st.ls   = 1'b0;
      end else if (boundary) begin
         nxt_st.ph   = TPWM_FORCED;
         nxt_st.ramp = CNT_RST;
         nxt_st.hs   = 1'b0;
         nxt_st.ls   = 1'b1;
      end else begin
         case (st_ff.ph)
            TPWM_FORCED: begin
               nxt_st.ls = 1'b1;
               if (st_ff.ramp == MID_LOW) begin
                  nxt_st.sample = 1'b1;
               end
               if (st_ff.ramp == THIRD - 8'd1) begin
                  nxt_st.ph = TPWM_ARMED;
               end
            end
            TPWM_ARMED: begin
               // Ramp crossing the threshold ends freewheeling first.
               if (st_ff.ramp >= thresh) begin
                  nxt_st.ls = 1'b0;
                  nxt_st.ph = TPWM_DEAD;
               end
            end
            TPWM_DEAD: begin
               nxt_st.hs = 1'b1;
               nxt_st.ph = TPWM_HIGH;
            end
            TPWM_HIGH: begin
               nxt_st.hs = 1'b1;
            end
            default: begin
               nxt_st.ph = TPWM_FORCED;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '{ph: TPWM_FORCED, ramp: CNT_RST, hs: 1'b0, ls: 1'b0, sample: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign hs     = st_ff.hs;
   assign ls     = st_ff.ls;
   assign sample = st_ff.sample;
endmodule // tpwm_chan

//--- logic/tpwm_top.sv
`timescale 1ns/10ps
// Two-phase interleaved PWM core with shared-path current balance.
module tpwm_top
   import tpwm_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                threshold_enable_input,
   input  wire logic [CNT_W-1:0]    error_word,
   input  wire logic [CUR_W-1:0]    shared_current_sense,
   output logic [NCH-1:0]           sense_select,
   output logic [NCH-1:0]           high_side_gate_drive,
   output logic [NCH-1:0]           low_side_gate_drive,
   output logic [CUR_W-1:0]         oc_current_0,
   output logic [CUR_W-1:0]         oc_current_1
);
   typedef struct packed {
      logic [CNT_W-1:0] clk_cnt;
      logic [CUR_W-1:0] cur0;
      logic [CUR_W-1:0] cur1;
      logic [NCH-1:0]   sel;
      logic [NCH-1:0]   hs;
      logic [NCH-1:0]   ls;
   } tpwm_top_st_t;

   tpwm_top_st_t st_ff;
   tpwm_top_st_t nxt_st;

   logic [NCH-1:0]   bnd;
   logic [NCH-1:0]   ch_hs;
   logic [NCH-1:0]   ch_ls;
   logic [NCH-1:0]   ch_smp;
   logic [CNT_W-1:0] thr [NCH];
   logic [CUR_W:0]   sum;
   logic [CUR_W-1:0] avg;

   // Master switching clock; channel two terminates half a cycle later.
   assign bnd[0] = (st_ff.clk_cnt == CNT_RST);
   assign bnd[1] = (st_ff.clk_cnt == HALF);

   // Average of the two sampled currents.
   assign sum = {1'b0, st_ff.cur0} + {1'b0, st_ff.cur1};
   assign avg = sum[CUR_W:1];

   // Threshold per channel: period minus error plus correction, clamped to 66 percent duty.
   // The mean is an argument, so a change on either leg re-evaluates both thresholds.
   function automatic logic [CNT_W-1:0] adj(input logic [CNT_W-1:0] e,
                                             input logic [CUR_W-1:0] c,
                                             input logic [CUR_W-1:0] m);
      logic signed [CNT_W+1:0] t;
      logic signed [CNT_W+1:0] lo;
      t  = $signed({2'b00, PERIOD}) - $signed({2'b00, e});
      t  = t + $signed({2'b00, c}) - $signed({2'b00, m});
      lo = $signed({2'b00, THIRD});
      if (t < lo) begin
         t = lo;
      end
      if (t > $signed({2'b00, PERIOD})) begin
         t = $signed({2'b00, PERIOD});
      end
      adj = t[CNT_W-1:0];
   endfunction

   assign thr[0] = adj(error_word, st_ff.cur0, avg);
   assign thr[1] = adj(error_word, st_ff.cur1, avg);

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         tpwm_chan u_ch (
            .clk      (clk),
            .arst_n   (arst_n),
            .en       (threshold_enable_input),
            .boundary (bnd[g]),
            .thresh   (thr[g]),
            .hs       (ch_hs[g]),
            .ls       (ch_ls[g]),
            .sample   (ch_smp[g])
         );
      end
   endgenerate

   // Cycle counter, sense mux select and sample capture.
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.hs  = ch_hs & ~ch_ls;
      nxt_st.ls  = ch_ls;
      nxt_st.sel = {1'b0, 1'b0};
      if (!threshold_enable_input) begin
         nxt_st.clk_cnt = CNT_RST;
         nxt_st.hs      = {1'b0, 1'b0};
         nxt_st.ls      = {1'b0, 1'b0};
      end else begin
         if (st_ff.clk_cnt == PERIOD - 8'd1) begin
            nxt_st.clk_cnt = CNT_RST;
         end else begin
            nxt_st.clk_cnt = st_ff.clk_cnt + 8'd1;
         end
         nxt_st.sel = ch_smp;
         // Sense input is read one cycle after the select settles.
         if (st_ff.sel[0]) begin
            nxt_st.cur0 = shared_current_sense;
         end
         if (st_ff.sel[1]) begin
            nxt_st.cur1 = shared_current_sense;
         end
      end
   end

   // State register.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '{clk_cnt: CNT_RST, cur0: CUR_RST, cur1: CUR_RST,
                    sel: 2'b00, hs: 2'b00, ls: 2'b00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign high_side_gate_drive = st_ff.hs;
   assign low_side_gate_drive  = st_ff.ls;
   assign sense_select         = st_ff.sel;
   assign oc_current_0         = st_ff.cur0;
   assign oc_current_1         = st_ff.cur1;
endmodule // tpwm_top

//--- testbench/tpwm_properties.sv
`timescale 1ns/10ps
// Gate timing, sampling and enable checks on the core's ports.
module tpwm_properties (
   input wire logic                      clk,
   input wire logic                      arst_n,
   input wire logic                      threshold_enable_input,
   input wire logic [tpwm_pkg::CUR_W-1:0] shared_current_sense,
   input wire logic [tpwm_pkg::NCH-1:0]   sense_select,
   input wire logic [tpwm_pkg::NCH-1:0]   high_side_gate_drive,
   input wire logic [tpwm_pkg::NCH-1:0]   low_side_gate_drive,
   input wire logic [tpwm_pkg::CUR_W-1:0] oc_current_0
);
   import tpwm_pkg::*;
   // Short aliases keep the properties on one line each.
   wire logic [NCH-1:0] h = high_side_gate_drive;
   wire logic [NCH-1:0] l = low_side_gate_drive;
   wire logic [NCH-1:0] s = sense_select;
   default clocking cb @(posedge clk); endclocking
   // Timing checks only mean something while the core runs.
   default disable iff (!arst_n || !threshold_enable_input);
   sequence s_pick0; s[0] ##1 1'b1; endsequence
   property p_nov; (h & l) == 2'b00; endproperty
   a_nov: assert property (p_nov) else $error("both gates on");
   property p_brk; $rose(h[0]) |-> !$past(l[0]); endproperty
   a_brk: assert property (p_brk) else $error("no break gap");
   property p_lsf; $fell(h[0]) |-> ##49 l[0]; endproperty
   a_lsf: assert property (p_lsf) else $error("low side short");
   property p_arm; $rose(h[0]) |-> !$past(h[0], 50); endproperty
   a_arm: assert property (p_arm) else $error("early turn on");
   property p_dut; $rose(h[0]) |-> ##[1:99] $fell(h[0]); endproperty
   a_dut: assert property (p_dut) else $error("pulse too long");
   property p_per; s[0] |-> ##150 s[0]; endproperty
   a_per: assert property (p_per) else $error("sample period");
   property p_ilv; s[0] |-> ##75 s[1]; endproperty
   a_ilv: assert property (p_ilv) else $error("phase offset");
   property p_one; $onehot0(s); endproperty
   a_one: assert property (p_one) else $error("two selects");
   property p_cap; s_pick0 |-> oc_current_0 == $past(shared_current_sense); endproperty
   a_cap: assert property (p_cap) else $error("bad capture");
   // Enable low must gate outputs even though timing checks are off.
   property p_off;
      disable iff (!arst_n) (!threshold_enable_input) [*2] |-> h == 2'b00 && l == 2'b00;
   endproperty
   a_off: assert property (p_off) else $error("gates on disabled");
endmodule // tpwm_properties
bind tpwm_top tpwm_properties tpwm_properties_i (.clk, .arst_n, .threshold_enable_input,
   .shared_current_sense, .sense_select, .high_side_gate_drive, .low_side_gate_drive,
   .oc_current_0);

//--- testbench/tpwm_stage_model.sv
`timescale 1ns/10ps
// Power stage pair returning the selected leg current on the shared path.
module tpwm_stage_model (
   input wire logic                      clk,
   input wire logic [tpwm_pkg::NCH-1:0]   sel,
   input wire logic [tpwm_pkg::CUR_W-1:0] i0,
   input wire logic [tpwm_pkg::CUR_W-1:0] i1,
   output logic     [tpwm_pkg::CUR_W-1:0] sense
);
   import tpwm_pkg::*;
   logic [CUR_W-1:0] idle_ff = CUR_RST;
   // An idle path toggles, so a capture outside the select window reads garbage.
   always @(posedge clk) begin
      idle_ff <= ~idle_ff;
   end
   // The selected leg stands for the whole select cycle, since the core reads it at its end.
   assign sense = sel[0] ? i0 : sel[1] ? i1 : idle_ff;
endmodule // tpwm_stage_model

//--- testbench/tpwm_top_tb.sv
`timescale 1ns/10ps
// Bench driving enable, error word and leg currents on the falling edge.
module tpwm_top_tb;
   import tpwm_pkg::*;
   logic             clk = 0, arst_n = 0, en = 0;
   logic [CNT_W-1:0] ew = 8'h00;
   logic [CUR_W-1:0] i0 = 8'h20, i1 = 8'h20, cs, oc0, oc1;
   logic [NCH-1:0]   sel, hs, ls;
   int               num_errors = 0, checks = 0, d0, d1, f0, f1, lc;
   always #50 clk = ~clk;
   tpwm_top tpwm_top_i (.clk(clk), .arst_n(arst_n), .threshold_enable_input(en),
      .error_word(ew), .shared_current_sense(cs), .sense_select(sel),
      .high_side_gate_drive(hs), .low_side_gate_drive(ls), .oc_current_0(oc0),
      .oc_current_1(oc1));
   tpwm_stage_model tpwm_stage_model_i (.clk(clk), .sel(sel), .i0(i0), .i1(i1), .sense(cs));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %0d exp %0d", $time, got, exp);
      end
   endtask
   task end_sim();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Settles, aligns to a channel-0 pulse end, then logs one full cycle.
   task meas(input int n);
      logic [NCH-1:0] p;
      {d0, d1, f0, f1, lc} = 0;
      p = 0;
      repeat (n) @(negedge clk);
      for (int k = 0; k < 400 && !(p[0] && !hs[0]); k++) begin
         p = hs;
         @(negedge clk);
      end
      for (int k = 0; k <= 150; k++) begin
         if (k > 0 && p[0] && !hs[0]) f0 = k;
         if (p[1] && !hs[1]) f1 = k;
         d0 += hs[0];
         d1 += hs[1];
         lc += ls[0];
         p = hs;
         @(negedge clk);
      end
   endtask
   // Duty tracks the error word one for one, and saturates at the cap.
   task t_duty();
      int a;
      ew = 8'h1e;
      meas(300);
      a = d0;
      ew = 8'h3c;
      meas(300);
      chk(f0, 150);
      chk(f1, 75);
      chk(d0 - a, 30);
      chk(d1, d0);
      ew = 8'hff;
      meas(300);
      chk(d0 <= 99, 1);
      chk(lc >= 50, 1);
      $display("duty test done");
   endtask
   // A hotter leg loses width by its excess over the mean.
   task t_bal();
      ew = 8'h3c;
      i0 = 8'h28;
      i1 = 8'h14;
      meas(450);
      chk(d1 - d0, 20);
      chk(oc0, 8'h28);
      chk(oc1, 8'h14);
      $display("balance test done");
   endtask
   // Enable drop mid-run gates both gate drives; re-enable restarts cleanly.
   task t_off();
      en = 0;
      repeat (3) @(negedge clk);
      chk({hs, ls}, 4'h0);
      en = 1;
      meas(300);
      chk(f0, 150);
      $display("enable test done");
   endtask
   // Reset held five cycles; outputs must be quiet at its end.
   initial begin
      repeat (5) @(negedge clk);
      chk({sel, hs, ls, oc0, oc1}, 0);
      arst_n = 1;
      @(negedge clk);
      en = 1;
      t_duty();
      t_bal();
      t_off();
      end_sim();
   end
   // The tests need a few thousand cycles; this cuts a hang well past that.
   initial begin
      #2000000;
      num_errors++;
      end_sim();
   end
endmodule // tpwm_top_tb
